// [logic/stc_pkg.sv]
// constants and types shared by the common command handler
package stc_pkg;

  // command codes on the command port
  localparam logic [2:0] STC_CMD_STB_QUERY = 3'h0;
  localparam logic [2:0] STC_CMD_SRE_SET = 3'h1;
  localparam logic [2:0] STC_CMD_SRE_QUERY = 3'h2;
  localparam logic [2:0] STC_CMD_TRIGGER = 3'h3;
  localparam logic [2:0] STC_CMD_TEST_QUERY = 3'h4;
  localparam logic [2:0] STC_CMD_WAIT = 3'h5;
  localparam logic [2:0] STC_CMD_MODE_SET = 3'h6;
  localparam logic [2:0] STC_CMD_EXT_SET = 3'h7;

  // status byte field positions
  localparam int STC_STB_DEV_BIT = 0;
  localparam int STC_STB_MAV_BIT = 4;
  localparam int STC_STB_ESB_BIT = 5;
  localparam int STC_STB_MSS_BIT = 6;

  // values after reset
  localparam logic [7:0] STC_SRE_RESET = 8'h00;
  localparam logic STC_EXT_EN_RESET = 1'b0;

  // self-test result range
  localparam logic [9:0] STC_TEST_MAX = 10'h291;
  localparam logic [9:0] STC_TEST_PASS = 10'h000;

  // wait-to-continue hold time
  localparam int STC_CLK_HZ = 40000000;
  localparam int STC_WAIT_MS = 2000;
  localparam int STC_WAIT_CYCLES = STC_CLK_HZ / 1000 * STC_WAIT_MS;
  localparam int STC_CNT_W = 27;

  // operating modes
  typedef enum logic [2:0] {
    STC_MODE_AUTO = 3'h0,
    STC_MODE_TRIG = 3'h1,
    STC_MODE_GATE = 3'h2,
    STC_MODE_BURST = 3'h3,
    STC_MODE_EXTERNAL_WIDTH = 3'h4
  } stc_mode_type;

  // controller states, one-hot
  typedef enum logic [2:0] {
    STC_ST_IDLE = 3'b001,
    STC_ST_TEST = 3'b010,
    STC_ST_HOLD = 3'b100
  } stc_state_type;

endpackage : stc_pkg

// [logic/stc_hold_timer.sv]
// down counter that times the wait-to-continue hold
`timescale 1ns/1ps
module stc_hold_timer #(
  parameter int CNT_W = 27,
  parameter logic [26:0] LOAD_VALUE = 27'h4C4B400
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // control
  input wire logic start,
  // status
  output logic expired
);

  // remaining cycles
  logic [CNT_W-1:0] count_q;
  logic running_q;

  // load on start, count to one, then flag expiry
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      count_q <= '0;
      running_q <= 1'b0;
      expired <= 1'b0;
    end else if (start) begin
      count_q <= LOAD_VALUE[CNT_W-1:0];
      running_q <= 1'b1;
      expired <= 1'b0;
    end else if (running_q) begin
      // last cycle of the hold
      if (count_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
        running_q <= 1'b0;
        expired <= 1'b1;
      end else begin
        count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        expired <= 1'b0;
      end
    end else begin
      expired <= 1'b0;
    end
  end

endmodule : stc_hold_timer

// [logic/stc_command_core.sv]
// status byte, trigger, self-test and wait handling of common commands
// Operation
// - status query returns eight-bit status byte
// - bits 6,5,4,0 carry summaries; others zero
// - software trigger acts as group execute trigger
// - trigger or burst mode fires one event
// - software trigger turns external trigger enable off
// - self-test query runs test, queues result
// - self-test result 0 to 657, zero passes
// - no commands accepted while self-test runs
// - setting restored after self-test completes
// - wait command holds execution two seconds
// - pending operations finish during the hold
// - enable register bits gate matching status bits
// - triggered mode fires per external or software trigger
`timescale 1ns/1ps
module stc_command_core #(
  parameter int WAIT_CYCLES = stc_pkg::STC_WAIT_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // command port
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [7:0] cmd_arg,
  output logic cmd_ready,
  // response into the output queue
  output logic resp_valid,
  output logic [9:0] resp_data,
  // bus trigger message and external trigger input
  input wire logic bus_trigger,
  input wire logic ext_trigger,
  // status sources
  input wire logic event_summary,
  input wire logic message_available,
  input wire logic device_flag,
  // pending operations
  input wire logic ops_pending,
  output logic ops_flush,
  // self-test engine
  output logic test_start,
  input wire logic test_done,
  input wire logic [9:0] test_code,
  // trigger and setting outputs
  output logic trigger_event,
  output logic ext_trigger_enable,
  output logic [2:0] operating_mode,
  output logic service_request
);
  import stc_pkg::*;

  // whole state of the handler
  typedef struct packed {
    // controller state
    stc_state_type state;
    // settings seen by the host
    logic [7:0] sre;
    logic ext_en;
    stc_mode_type mode;
    // setting parked while the self-test runs
    logic saved_ext_en;
    stc_mode_type saved_mode;
    // registered outputs
    logic ready;
    logic resp_valid;
    logic [9:0] resp_data;
    logic test_start;
    logic trig;
    logic flush;
    logic srq;
    // hold bookkeeping: timer ran out before work drained
    logic timer_seen;
  } stc_regs_type;

  // current and next state
  stc_regs_type regs_q;
  stc_regs_type regs_d;

  // hold timer control and status
  logic timer_start;
  logic timer_expired;
  // composed status byte
  logic [7:0] status_byte;
  logic [7:0] status_low;
  logic summary;
  logic take;
  logic sw_trig;
  logic trig_mode;

  // load value cut to the counter width on purpose; the two-second
  // figure at this clock fits 27 bits with room to spare
  localparam logic [26:0] STC_TIMER_LOAD = 27'(WAIT_CYCLES);

  // hold timer for the wait command
  // the counter is the only wide register, kept in its own module
  stc_hold_timer #(
    .CNT_W(STC_CNT_W),
    .LOAD_VALUE(STC_TIMER_LOAD)
  ) u_hold_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .start(timer_start),
    .expired(timer_expired)
  );

  // status byte assembly
  always_comb begin
    // unused bits 7, 3, 2 and 1 stay zero from here on
    status_low = 8'h00;
    // device flag, message available, event summary
    status_low[STC_STB_DEV_BIT] = device_flag;
    status_low[STC_STB_MAV_BIT] = message_available;
    status_low[STC_STB_ESB_BIT] = event_summary;
    // enabled bits form the master summary
    summary = |(status_low & regs_q.sre);
    status_byte = status_low;
    status_byte[STC_STB_MSS_BIT] = summary;
  end

  // command acceptance only while ready
  // ready is registered, so it drops only the cycle after a test or
  // wait command is taken; a refused command is not queued
  assign take = cmd_valid & regs_q.ready;
  // software trigger or bus trigger message, same path
  // the bus message is ignored while busy, like a command
  assign sw_trig = (take & (cmd_code == STC_CMD_TRIGGER)) |
    (bus_trigger & regs_q.ready);
  // modes that answer a trigger event
  // auto, gate and external width ignore trigger events
  assign trig_mode = (regs_q.mode == STC_MODE_TRIG) |
    (regs_q.mode == STC_MODE_BURST);
  // start the timer on an accepted wait command
  assign timer_start = take & (cmd_code == STC_CMD_WAIT);

  // next-state logic
  always_comb begin
    regs_d = regs_q;
    // pulses last one cycle unless set again below
    regs_d.resp_valid = 1'b0;
    regs_d.test_start = 1'b0;
    regs_d.trig = 1'b0;
    // summary lags status bit 6 by one register
    regs_d.srq = summary;
    // external trigger when enabled in a triggering mode
    // the external input stays live during test and hold
    if (regs_q.ext_en && ext_trigger && trig_mode) begin
      regs_d.trig = 1'b1;
    end
    // software trigger path
    // enable clears in every mode, the pulse only when triggering
    if (sw_trig) begin
      regs_d.trig = trig_mode;
      regs_d.ext_en = 1'b0;
    end
    case (regs_q.state)
      // waiting for commands
      STC_ST_IDLE: begin
        regs_d.ready = 1'b1;
        if (take) begin
          case (cmd_code)
            // status byte query
            STC_CMD_STB_QUERY: begin
              // two top bits of the reply word stay zero
              regs_d.resp_valid = 1'b1;
              regs_d.resp_data = {2'b00, status_byte};
            end
            // enable register write
            STC_CMD_SRE_SET: begin
              regs_d.sre = cmd_arg;
            end
            // enable register query
            STC_CMD_SRE_QUERY: begin
              regs_d.resp_valid = 1'b1;
              regs_d.resp_data = {2'b00, regs_q.sre};
            end
            // self-test: save setting, lock out commands
            STC_CMD_TEST_QUERY: begin
              regs_d.saved_ext_en = regs_q.ext_en;
              regs_d.saved_mode = regs_q.mode;
              regs_d.test_start = 1'b1;
              regs_d.ready = 1'b0;
              regs_d.state = STC_ST_TEST;
            end
            // wait: hold and flush pending work
            STC_CMD_WAIT: begin
              // the timer starts from the same take, outside this process
              regs_d.ready = 1'b0;
              regs_d.flush = 1'b1;
              regs_d.timer_seen = 1'b0;
              regs_d.state = STC_ST_HOLD;
            end
            // operating mode setting
            STC_CMD_MODE_SET: begin
              // codes above external width are ignored
              if (cmd_arg[2:0] <= 3'(STC_MODE_EXTERNAL_WIDTH)) begin
                regs_d.mode = stc_mode_type'(cmd_arg[2:0]);
              end
            end
            // external trigger enable setting
            STC_CMD_EXT_SET: begin
              // bit zero of the argument is the enable
              regs_d.ext_en = cmd_arg[0];
            end
            // software trigger handled above
            default: begin
              regs_d.ready = 1'b1;
            end
          endcase
        end
      end
      // self-test running, commands refused
      STC_ST_TEST: begin
        regs_d.ready = 1'b0;
        if (test_done) begin
          regs_d.resp_valid = 1'b1;
          // clamp out-of-range codes to the top failure code
          if (test_code > STC_TEST_MAX) begin
            regs_d.resp_data = STC_TEST_MAX;
          end else begin
            regs_d.resp_data = test_code;
          end
          // put back the setting active when the query was taken
          regs_d.ext_en = regs_q.saved_ext_en;
          regs_d.mode = regs_q.saved_mode;
          regs_d.ready = 1'b1;
          regs_d.state = STC_ST_IDLE;
        end
      end
      // wait hold: two seconds, then pending work must be done
      STC_ST_HOLD: begin
        regs_d.ready = 1'b0;
        // remember expiry, the timer flags it for one cycle only
        if (timer_expired) begin
          regs_d.timer_seen = 1'b1;
        end
        // release once time is up and nothing is pending
        if ((timer_expired || regs_q.timer_seen) && !ops_pending) begin
          regs_d.flush = 1'b0;
          regs_d.ready = 1'b1;
          regs_d.state = STC_ST_IDLE;
        end
      end
      // recover from an illegal code
      default: begin
        regs_d.state = STC_ST_IDLE;
        regs_d.ready = 1'b1;
        regs_d.flush = 1'b0;
      end
    endcase
  end

  // state register
  // synchronous reset; every field gets a constant
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      // controller idle, settings at power-on values
      regs_q.state <= STC_ST_IDLE;
      regs_q.sre <= STC_SRE_RESET;
      regs_q.ext_en <= STC_EXT_EN_RESET;
      regs_q.mode <= STC_MODE_AUTO;
      // saved setting matches the live one
      regs_q.saved_ext_en <= STC_EXT_EN_RESET;
      regs_q.saved_mode <= STC_MODE_AUTO;
      // outputs quiet, commands refused until the next edge
      regs_q.ready <= 1'b0;
      regs_q.resp_valid <= 1'b0;
      regs_q.resp_data <= STC_TEST_PASS;
      regs_q.test_start <= 1'b0;
      regs_q.trig <= 1'b0;
      // no hold in progress
      regs_q.flush <= 1'b0;
      regs_q.srq <= 1'b0;
      regs_q.timer_seen <= 1'b0;
    end else begin
      regs_q <= regs_d;
    end
  end

  // outputs straight from the state register
  // command handshake
  assign cmd_ready = regs_q.ready;
  // reply pulse into the output queue
  assign resp_valid = regs_q.resp_valid;
  // reply word, held until the next reply
  assign resp_data = regs_q.resp_data;

  // one-cycle start pulse for the self-test engine
  assign test_start = regs_q.test_start;
  // one-cycle trigger pulse
  assign trigger_event = regs_q.trig;
  // asks pending operations to finish during the hold
  assign ops_flush = regs_q.flush;

  // live external trigger enable
  assign ext_trigger_enable = regs_q.ext_en;
  // live operating mode
  assign operating_mode = regs_q.mode;

  // master summary, one cycle behind status bit 6
  assign service_request = regs_q.srq;

endmodule : stc_command_core

// [bench/stc_test_model.sv]
// self-test engine model answering the handler's start pulse
`timescale 1ns/1ps
module stc_test_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // start and result
  input wire logic test_start,
  input wire logic [9:0] result,
  output logic test_done,
  output logic [9:0] test_code
);
  int left_q = 0; // cycles until the result
  initial test_done = 1'b0;
  initial test_code = 10'h155;
  // result line toggles outside the done pulse
  always @(posedge ref_clk) begin
    if (reset) left_q <= 0;
    else if (test_start) left_q <= 12;
    else if (left_q > 0) left_q <= left_q - 1;
    test_done <= (left_q == 1);
    test_code <= (left_q == 1) ? result : ~test_code;
  end
endmodule : stc_test_model

// [bench/stc_checker_assertions.sv]
// assertion checker bound to the common command handler
`timescale 1ns/1ps
module stc_checker import stc_pkg::*; #(parameter int WAIT_CYCLES = 20) (
  // clock and reset
  input wire logic ref_clk, input wire logic reset,
  // command port
  input wire logic cmd_valid, input wire logic [2:0] cmd_code,
  input wire logic cmd_ready, input wire logic resp_valid,
  input wire logic [9:0] resp_data,
  // triggers, status, pending work, self-test
  input wire logic bus_trigger, input wire logic ext_trigger,
  input wire logic event_summary, input wire logic message_available,
  input wire logic device_flag, input wire logic ops_pending,
  input wire logic ops_flush, input wire logic test_start,
  input wire logic test_done, input wire logic [9:0] test_code,
  input wire logic trigger_event, input wire logic ext_trigger_enable,
  input wire logic [2:0] operating_mode, input wire logic service_request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic tk; // command taken
  int hold_cnt_q; // cycles spent flushing
  assign tk = cmd_valid && cmd_ready;
  // counts hold cycles of a wait
  always_ff @(posedge ref_clk) begin
    if (reset || cmd_ready) hold_cnt_q <= 0;
    else if (ops_flush) hold_cnt_q <= hold_cnt_q + 1;
  end
  stb_reply_a: assert property (
    tk && cmd_code == STC_CMD_STB_QUERY |=> resp_valid
    && resp_data[9:7] == 3'h0 && resp_data[3:1] == 3'h0)
    else $error("status reply malformed");
  sw_fire_a: assert property (
    tk && cmd_code == STC_CMD_TRIGGER && operating_mode inside
    {STC_MODE_TRIG, STC_MODE_BURST} |=> trigger_event)
    else $error("software trigger did not fire");
  ext_off_a: assert property (
    tk && cmd_code == STC_CMD_TRIGGER |=> !ext_trigger_enable)
    else $error("external enable not cleared");
  test_go_a: assert property (
    tk && cmd_code == STC_CMD_TEST_QUERY |=> test_start && !cmd_ready)
    else $error("self-test not started");
  test_code_a: assert property (
    test_done && !cmd_ready && !ops_flush |=> resp_valid && resp_data ==
    ($past(test_code) > STC_TEST_MAX ? STC_TEST_MAX : $past(test_code)))
    else $error("self-test result wrong");
  busy_lock_a: assert property (
    !cmd_ready && bus_trigger && !ext_trigger |=> !trigger_event)
    else $error("bus trigger taken while busy");
  ext_fire_a: assert property (
    ext_trigger && ext_trigger_enable && operating_mode == STC_MODE_TRIG
    |=> trigger_event) else $error("external trigger lost");
  mss_off_a: assert property (
    !(event_summary || message_available || device_flag) [*3]
    |=> !service_request) else $error("service request without cause");
  hold_flush_a: assert property (
    ops_flush && ops_pending |=> !cmd_ready)
    else $error("hold ended with work pending");
  wait_len_a: assert property (
    $rose(cmd_ready) && $past(ops_flush) |-> hold_cnt_q >= WAIT_CYCLES)
    else $error("wait hold too short");
endmodule : stc_checker
bind stc_command_core stc_checker #(.WAIT_CYCLES(WAIT_CYCLES)) chk (.*);

// [bench/tb.sv]
// self-checking bench for the common command handler
`timescale 1ns/1ps
module tb;
  import stc_pkg::*;
  logic ref_clk = 0, reset = 1, cmd_valid = 0, bus_trigger = 0;
  logic ext_trigger = 0, event_summary = 0, message_available = 0;
  logic device_flag = 0, ops_pending = 0;
  logic [2:0] cmd_code = 3'h0;
  logic [7:0] cmd_arg = 8'h00;
  logic [9:0] tst_res = 10'h000; // result the model reports
  logic cmd_ready, resp_valid, ops_flush, test_start, test_done;
  logic trigger_event, ext_trigger_enable, service_request;
  logic [9:0] resp_data, test_code;
  logic [2:0] operating_mode;
  int miscompares = 0, compares = 0, n;
  always #12.5 ref_clk = ~ref_clk;
  stc_command_core #(.WAIT_CYCLES(20)) uut (.*);
  stc_test_model model (.ref_clk(ref_clk), .reset(reset),
    .test_start(test_start), .result(tst_res), .test_done(test_done),
    .test_code(test_code));
  // one comparison of a result
  task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // issue a command, hold it until taken, end at the next negedge
  task automatic cmd(logic [2:0] c, logic [7:0] a);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_arg <= a;
    for (int i = 0; i < 200; i++) begin
      @(posedge ref_clk);
      if (cmd_ready === 1'b1) break;
    end
    cmd_valid <= 1'b0;
    @(negedge ref_clk);
  endtask : cmd
  // query with expected reply
  task automatic q(logic [2:0] c, logic [9:0] e);
    cmd(c, 8'h00);
    chk("resp_valid", 10'h001, {9'h0, resp_valid});
    chk("resp_data", e, resp_data);
  endtask : q
  // one-cycle pulse on bus or external trigger
  task automatic pulse(bit bus);
    @(posedge ref_clk);
    if (bus) bus_trigger <= 1'b1;
    else ext_trigger <= 1'b1;
    @(posedge ref_clk);
    bus_trigger <= 1'b0;
    ext_trigger <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse
  // wait for ready to return, counting cycles
  task automatic wait_ready();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
  endtask : wait_ready
  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude
  // hang guard
  initial begin
    #(25 * 4000);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    q(STC_CMD_STB_QUERY, 10'h000);
    @(posedge ref_clk);
    {event_summary, message_available, device_flag} <= 3'b111;
    q(STC_CMD_STB_QUERY, 10'h031);
    cmd(STC_CMD_SRE_SET, 8'h20);
    q(STC_CMD_STB_QUERY, 10'h071);
    chk("service_request", 10'h001, {9'h0, service_request});
    q(STC_CMD_SRE_QUERY, 10'h020);
    cmd(STC_CMD_SRE_SET, 8'h8E);
    q(STC_CMD_STB_QUERY, 10'h031);
    for (int m = 0; m < 5; m++) begin
      cmd(STC_CMD_MODE_SET, 8'(m));
      cmd(STC_CMD_EXT_SET, 8'h01);
      cmd(STC_CMD_TRIGGER, 8'h00);
      chk("trig", 10'(m == 1 || m == 3), {9'h0, trigger_event});
      chk("ext_en", 10'h000, {9'h0, ext_trigger_enable});
    end
    cmd(STC_CMD_MODE_SET, 8'h01);
    cmd(STC_CMD_EXT_SET, 8'h01);
    pulse(1'b0);
    chk("ext_fire", 10'h001, {9'h0, trigger_event});
    pulse(1'b1);
    chk("bus_fire", 10'h001, {9'h0, trigger_event});
    chk("bus_ext", 10'h000, {9'h0, ext_trigger_enable});
    for (int k = 0; k < 2; k++) begin
      tst_res <= k ? 10'h2C8 : 10'h000;
      cmd(STC_CMD_MODE_SET, 8'h03);
      cmd(STC_CMD_EXT_SET, 8'h01);
      cmd(STC_CMD_TEST_QUERY, 8'h00);
      chk("test_start", 10'h001, {9'h0, test_start});
      @(posedge ref_clk);
      {cmd_valid, cmd_code, cmd_arg} <= {1'b1, STC_CMD_MODE_SET, 8'h00};
      bus_trigger <= 1'b1;
      @(posedge ref_clk);
      bus_trigger <= 1'b0;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      @(negedge ref_clk);
      chk("busy_trig", 10'h000, {9'h0, trigger_event});
      n = 0;
      while (resp_valid !== 1'b1 && n < 100) begin
        @(negedge ref_clk);
        n++;
      end
      chk("test_code", k ? STC_TEST_MAX : STC_TEST_PASS, resp_data);
      chk("mode", 10'h003, {7'h0, operating_mode});
      chk("ext", 10'h001, {9'h0, ext_trigger_enable});
    end
    @(posedge ref_clk);
    ops_pending <= 1'b1;
    cmd(STC_CMD_WAIT, 8'h00);
    repeat (40) @(negedge ref_clk);
    chk("flush", 10'h001, {9'h0, ops_flush});
    chk("held", 10'h000, {9'h0, cmd_ready});
    @(posedge ref_clk);
    ops_pending <= 1'b0;
    wait_ready();
    chk("released", 10'h001, {9'h0, cmd_ready});
    cmd(STC_CMD_WAIT, 8'h00);
    wait_ready();
    chk("wait_len", 10'h001, {9'h0, n >= 20 && n <= 25});
    q(STC_CMD_STB_QUERY, 10'h031);
    conclude();
  end
endmodule : tb
